/* File: rtl/format2_address_and_load_exec.sv */
// Purpose: Execution address forming and load group for format 2 words.
// Assumes: Memory returns the word at addr_o by phase T06 of each cycle.
// Notes:   The data register holds the one's complement of memory data.
// How it works
// - Direct mode uses the displacement, recovered from inverted data low byte.
// - Modes X1/X9 add displacement to first index register.
// - Modes X2/XA add displacement to second index register.
// - Modes X3/XB add displacement to the address register.
// - Indirect modes drop fetch status, load displacement to address, read.
// - Plain indirect sets cycle-two flag at T01, uses memory word.
// - Modes X5/XD add memory word to first index register.
// - Modes X6/XE add memory word to second index register.
// - Modes X7/XF subtract displacement from address using complement plus one.
// - Codes 18XX-1FXX put the execution address into the accumulator.
// - Codes 20XX-27XX put the execution address into index one.
// - Codes 28XX-2FXX put the execution address into index two.
// - Codes 30XX-37XX compare operand to index one, set flag or increment.
// - Codes 38XX-3FXX do the same with index two, then fetch.
// - Codes 40XX-47XX load operand into accumulator at next fetch T00.
// - Codes 48XX-4FXX load two's complement of the operand.
// - Codes 50XX-57XX load operand left byte, right byte zero, at T00.
// - Byte shift controls stay active T01 through T09 of that fetch.
// - Shift network shifts accumulator right eight, end-off, zero fill.
// - At T05 the shifted value loads, low five bits re-inverted.
// - Direct and relative modes finish in fetch except codes 30XX-57XX, which add an operand cycle; indirect adds a cycle.
// - Indirect jump with absent condition skips the indirect cycle.
`timescale 1ns/1ps
`include "f2_exec_defs.svh"
module format2_address_and_load_exec
(
	input  wire logic                    clk_i,
	input  wire logic                    rst_n_i,
	input  wire logic [15:0]             mem_data_i,
	input  wire logic [15:0]             pointer_i,
	input  wire logic                    jump_i,
	input  wire logic                    jump_cond_i,
	output logic      [15:0]             addr_o,
	output logic                         mem_read_o,
	output f2_exec_pkg::cycle_t          cycle_o,
	output logic      [3:0]              phase_o,
	output f2_exec_pkg::arch_regs_t      regs_o,
	output logic                         condition_flag_o,
	output logic                         indirect_cycle_two_o,
	output logic                         next_fetch_status_o,
	output f2_exec_pkg::byte_ctl_t       byte_ctl_o
);
	import f2_exec_pkg::*;

	// Reset release through two flops; assertion stays asynchronous.
	logic        rst_meta_r;
	logic        rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i)
	begin
		if (!rst_n_i)
		begin
			rst_meta_r <= 1'b0;
			rst_n      <= 1'b0;
		end
		else
		begin
			rst_meta_r <= 1'b1;
			rst_n      <= rst_meta_r;
		end
	end

	// Phase timing: a divider gives one enable pulse per phase step.
	localparam logic [`F2_DIV_W-1:0] DIV_LAST =
		`F2_DIV_W'(`F2_PHASE_CYC - 1);

	logic [`F2_DIV_W-1:0] div_r;
	logic [3:0]           phase_r;
	logic [3:0]           phase_nxt;
	logic                 tick;
	logic                 at_t00;
	logic                 at_t01;
	logic                 at_t05;
	logic                 at_t06;

	assign tick      = (div_r == DIV_LAST);
	assign phase_nxt = (phase_r == `F2_T09) ? `F2_T00 : phase_r + 4'h1;
	assign at_t00    = tick && (phase_nxt == `F2_T00);
	assign at_t01    = tick && (phase_nxt == `F2_T01);
	assign at_t05    = tick && (phase_nxt == `F2_T05);
	assign at_t06    = tick && (phase_nxt == `F2_T06);

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			div_r   <= '0;
			phase_r <= `F2_T00;
		end
		else
		begin
			div_r <= tick ? '0 : div_r + `F2_DIV_W'(1);
			if (tick)
				phase_r <= phase_nxt;
		end
	end

	// Architectural and working registers.
	cycle_t      cyc_r;
	logic [15:0] s_r;
	logic [15:0] x_r;
	logic [7:0]  f_r;
	logic [15:0] acc_r;
	logic [15:0] idx1_r;
	logic [15:0] idx2_r;
	logic        cond_r;
	logic        indirect_cycle_two_ff_r;
	logic        lby_r;
	logic        mem_read_r;

	// Instruction decode.
	logic [2:0]  mode;
	logic [4:0]  grp;
	logic        is_fetch;
	logic        is_ind;
	logic        is_oper;
	logic        ind_mode;
	logic        enter_acc;
	logic        enter_idx1;
	logic        enter_idx2;
	logic        test_idx1;
	logic        test_idx2;
	logic        load_true;
	logic        load_comp;
	logic        load_left;
	logic        needs_oper;
	logic        skip_ind;

	assign mode       = f_r[2:0];
	assign grp        = f_r[7:3];
	assign is_fetch   = (cyc_r == CYC_FETCH);
	assign is_ind     = (cyc_r == CYC_INDIRECT);
	assign is_oper    = (cyc_r == CYC_OPERAND);
	assign ind_mode   = (mode == `F2_MODE_IND) ||
	                    (mode == `F2_MODE_IND_IDX1) ||
	                    (mode == `F2_MODE_IND_IDX2);
	assign enter_acc  = (grp == `F2_GRP_ENTER_ACC);
	assign enter_idx1 = (grp == `F2_GRP_ENTER_IDX1);
	assign enter_idx2 = (grp == `F2_GRP_ENTER_IDX2);
	assign test_idx1  = (grp == `F2_GRP_TEST_IDX1);
	assign test_idx2  = (grp == `F2_GRP_TEST_IDX2);
	assign load_true  = (grp == `F2_GRP_LOAD);
	assign load_comp  = (grp == `F2_GRP_LOAD_COMP);
	assign load_left  = (grp == `F2_GRP_LOAD_LEFT);
	assign needs_oper = test_idx1 || test_idx2 || load_true ||
	                    load_comp || load_left;
	assign skip_ind   = jump_i && !jump_cond_i;

	// Address formation is valid once the fetched word sits in X.
	logic fetch_word;
	logic addr_phase;
	logic rel_back;

	assign fetch_word = is_fetch && (phase_r >= `F2_T06);
	assign addr_phase = fetch_word || is_ind;
	assign rel_back   = fetch_word && (mode == `F2_MODE_REL_BACK);

	// The indirect word enters the adder only once cycle two is set.
	logic ind_word;

	assign ind_word = is_ind && indirect_cycle_two_ff_r;

	// Adder input one selection.
	logic index_one_adder_gate;
	logic index_two_adder_gate;
	logic address_reg_adder_gate;
	logic enable_index_one_to_adder;
	logic enable_index_two_to_adder;

	assign enable_index_one_to_adder =
		(fetch_word && (mode == `F2_MODE_IDX1)) ||
		(ind_word && (mode == `F2_MODE_IND_IDX1)) ||
		(is_oper && test_idx1);
	assign enable_index_two_to_adder =
		(fetch_word && (mode == `F2_MODE_IDX2)) ||
		(ind_word && (mode == `F2_MODE_IND_IDX2)) ||
		(is_oper && test_idx2);
	assign index_one_adder_gate   = enable_index_one_to_adder;
	assign index_two_adder_gate   = enable_index_two_to_adder;
	assign address_reg_adder_gate = fetch_word &&
		((mode == `F2_MODE_REL_FWD) || rel_back);

	logic [15:0] adder_a;

	assign adder_a = index_one_adder_gate   ? idx1_r :
	                 index_two_adder_gate   ? idx2_r :
	                 address_reg_adder_gate ? s_r    : 16'h0000;

	// Adder input two: true and complement gates of the data register.
	logic enable_data_to_operand_gate;
	logic enable_negated_data_gate;
	logic low_byte_complement_gate;
	logic high_byte_complement_gate;
	logic true_data_gate;

	assign enable_data_to_operand_gate = (addr_phase && !ind_word) &&
	                                     !rel_back;
	assign enable_negated_data_gate    = rel_back ||
	                                     (is_oper && load_comp);
	assign true_data_gate            = enable_negated_data_gate;
	assign low_byte_complement_gate  = enable_data_to_operand_gate ||
	                                   ind_word ||
	                                   (is_oper && load_true);
	assign high_byte_complement_gate = ind_word ||
	                                   (is_oper && (load_true || load_left));

	logic [15:0] adder_b;
	logic [15:0] neg_data;

	// Backward mode sees the inverted displacement with a ones upper byte.
	assign neg_data = rel_back ? {8'hFF, x_r[7:0]} : x_r;
	assign adder_b  = (true_data_gate ? neg_data : 16'h0000) |
	                  (low_byte_complement_gate ?
	                   {8'h00, ~x_r[7:0]} : 16'h0000) |
	                  (high_byte_complement_gate ?
	                   {~x_r[15:8], 8'h00} : 16'h0000);

	logic forced_carry_in;

	assign forced_carry_in = enable_negated_data_gate ||
	                         (is_oper && (test_idx1 || test_idx2));

	logic [15:0] sum;

	adder16 u_adder
	(
		.a_i   (adder_a),
		.b_i   (adder_b),
		.cin_i (forced_carry_in),
		.sum_o (sum)
	);

	logic [15:0] result_bus;
	logic        sum_output_gate;

	assign sum_output_gate = 1'b1;
	assign result_bus      = sum_output_gate ? sum : 16'h0000;

	// Operand compare for the test index group.
	logic [15:0] operand;
	logic        idx_match;

	assign operand   = ~x_r;
	assign idx_match = test_idx1 ? (operand == idx1_r) :
	                               (operand == idx2_r);

	// Fetch status drops as soon as an indirect word is decoded.
	logic next_fetch_status;
	logic pointer_to_address_gate;
	logic go_ind;

	assign go_ind            = ind_mode && !skip_ind;
	assign next_fetch_status = !(fetch_word && go_ind);
	assign pointer_to_address_gate = next_fetch_status;

	// Cycle sequencing: decisions take effect at T00 of the next cycle.
	cycle_t      cyc_nxt;
	logic        address_reg_clock;
	logic [15:0] s_nxt;
	logic        finish;

	always_comb
	begin
		cyc_nxt           = CYC_FETCH;
		address_reg_clock = 1'b1;
		finish            = 1'b0;
		case (cyc_r)
			CYC_FETCH:
			begin
				if (go_ind)
					cyc_nxt = CYC_INDIRECT;
				else if (ind_mode)
					address_reg_clock = 1'b0;
				else if (needs_oper)
					cyc_nxt = CYC_OPERAND;
				else
				begin
					address_reg_clock = 1'b0;
					finish            = 1'b1;
				end
			end
			CYC_INDIRECT:
			begin
				if (needs_oper)
					cyc_nxt = CYC_OPERAND;
				else
				begin
					address_reg_clock = 1'b0;
					finish            = 1'b1;
				end
			end
			CYC_OPERAND:
			begin
				address_reg_clock = 1'b0;
				finish            = 1'b1;
			end
			default:
			begin
				address_reg_clock = 1'b0;
			end
		endcase
	end

	// Pointer gating is low only for an indirect fetch; address_reg_clock also routes the adder to the address reg.
	assign s_nxt = (address_reg_clock || !pointer_to_address_gate) ?
	               result_bus : pointer_i;

	// Destination clocks, taken at T00 closing the last cycle, except the byte load at T05.
	logic accumulator_clock;
	logic index_one_clock;
	logic index_two_clock;
	logic index_one_load_enable;
	logic index_two_load_enable;
	logic cond_update;

	assign index_one_load_enable = finish &&
		(enter_idx1 || (test_idx1 && !idx_match));
	assign index_two_load_enable = finish &&
		(enter_idx2 || (test_idx2 && !idx_match));
	assign cond_update     = finish && (test_idx1 || test_idx2);
	assign index_one_clock = at_t00 && index_one_load_enable;
	assign index_two_clock = at_t00 && index_two_load_enable;

	// Byte load: shift right eight end-off, low five bits through inverter.
	logic        right_shift_eight;
	logic        byte_load_select;
	logic        byte_load_clock_enable;
	logic        low_bits_inverter;
	logic [15:0] shift_net;
	logic [15:0] byte_bus;

	assign right_shift_eight      = lby_r && (phase_r != `F2_T00);
	assign byte_load_select       = right_shift_eight;
	assign byte_load_clock_enable = right_shift_eight;
	assign low_bits_inverter      = byte_load_select;
	// The network hands out its five low bits inverted; the stage fixes it.
	assign shift_net = (acc_r >> `F2_BYTE_SHIFT) ^ `F2_LOW_INV_MASK;
	assign byte_bus  = low_bits_inverter ?
	                   (shift_net ^ `F2_LOW_INV_MASK) : shift_net;

	logic        acc_load_word;
	logic        acc_load_byte;

	assign acc_load_word = at_t00 && finish &&
		(enter_acc || load_true || load_comp || load_left);
	assign acc_load_byte = at_t05 && byte_load_clock_enable;
	assign accumulator_clock = acc_load_word || acc_load_byte;

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			cyc_r  <= CYC_FETCH;
			s_r    <= `F2_RESET_WORD;
			x_r    <= `F2_RESET_WORD;
			f_r    <= 8'h00;
			indirect_cycle_two_ff_r <= 1'b0;
		end
		else
		begin
			if (at_t06)
				x_r <= ~mem_data_i;
			if (at_t06 && is_fetch)
				f_r <= mem_data_i[15:8];
			if (at_t01 && is_ind && (mode == `F2_MODE_IND ||
			    ind_mode))
				indirect_cycle_two_ff_r <= 1'b1;
			else if (at_t00)
				indirect_cycle_two_ff_r <= 1'b0;
			if (at_t00)
			begin
				cyc_r <= cyc_nxt;
				s_r   <= s_nxt;
			end
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
		begin
			acc_r  <= `F2_RESET_WORD;
			idx1_r <= `F2_RESET_WORD;
			idx2_r <= `F2_RESET_WORD;
			cond_r <= 1'b0;
			lby_r  <= 1'b0;
		end
		else
		begin
			if (acc_load_byte)
				acc_r <= byte_bus;
			else if (accumulator_clock)
				acc_r <= result_bus;
			if (index_one_clock)
				idx1_r <= result_bus;
			if (index_two_clock)
				idx2_r <= result_bus;
			if (at_t00 && cond_update)
				cond_r <= idx_match;
			if (at_t00)
				lby_r <= finish && load_left;
		end
	end

	always_ff @(posedge clk_i or negedge rst_n)
	begin
		if (!rst_n)
			mem_read_r <= 1'b0;
		else
			mem_read_r <= at_t01;
	end

	assign addr_o               = s_r;
	assign mem_read_o           = mem_read_r;
	assign cycle_o              = cyc_r;
	assign phase_o              = phase_r;
	assign regs_o.acc           = acc_r;
	assign regs_o.idx1          = idx1_r;
	assign regs_o.idx2          = idx2_r;
	assign condition_flag_o     = cond_r;
	assign indirect_cycle_two_o = indirect_cycle_two_ff_r;
	assign next_fetch_status_o  = next_fetch_status;
	assign byte_ctl_o.right_shift_eight      = right_shift_eight;
	assign byte_ctl_o.byte_load_select       = byte_load_select;
	assign byte_ctl_o.byte_load_clock_enable = byte_load_clock_enable;

endmodule // format2_address_and_load_exec

/* File: rtl/f2_exec_defs.svh */
// Purpose: Constants for the format 2 address and load execution block.
// Assumes: 40 MHz clock, ten internal phases T00..T09 per cycle.
// Notes:   Phase length in clocks comes from F2_PHASE_NS and F2_CLK_MHZ, rounded up.
`ifndef F2_EXEC_DEFS_SVH
`define F2_EXEC_DEFS_SVH

`define F2_CLK_MHZ        40
`define F2_PHASE_NS       100
`define F2_PHASE_CYC      ((`F2_PHASE_NS * `F2_CLK_MHZ + 999) / 1000)
`define F2_DIV_W          4

`define F2_T00            4'h0
`define F2_T01            4'h1
`define F2_T05            4'h5
`define F2_T06            4'h6
`define F2_T09            4'h9

`define F2_MODE_DIRECT    3'h0
`define F2_MODE_IDX1      3'h1
`define F2_MODE_IDX2      3'h2
`define F2_MODE_REL_FWD   3'h3
`define F2_MODE_IND       3'h4
`define F2_MODE_IND_IDX1  3'h5
`define F2_MODE_IND_IDX2  3'h6
`define F2_MODE_REL_BACK  3'h7

`define F2_GRP_ENTER_ACC  5'h03
`define F2_GRP_ENTER_IDX1 5'h04
`define F2_GRP_ENTER_IDX2 5'h05
`define F2_GRP_TEST_IDX1  5'h06
`define F2_GRP_TEST_IDX2  5'h07
`define F2_GRP_LOAD       5'h08
`define F2_GRP_LOAD_COMP  5'h09
`define F2_GRP_LOAD_LEFT  5'h0A

`define F2_LOW_INV_MASK   16'h001F
`define F2_BYTE_SHIFT     8
`define F2_RESET_WORD     16'h0000

`endif

/* File: rtl/f2_exec_pkg.sv */
// Purpose: Types shared by the format 2 execution block and its bench.
// Assumes: Constants live in f2_exec_defs.svh.
// Notes:   Types only.
package f2_exec_pkg;

	typedef enum logic [1:0] {
		CYC_FETCH,
		CYC_INDIRECT,
		CYC_OPERAND
	} cycle_t;

	typedef struct packed {
		logic [15:0] acc;
		logic [15:0] idx1;
		logic [15:0] idx2;
	} arch_regs_t;

	typedef struct packed {
		logic right_shift_eight;
		logic byte_load_select;
		logic byte_load_clock_enable;
	} byte_ctl_t;

endpackage

/* File: rtl/adder16.sv */
// Purpose: Sixteen-bit adder with carry-in used for address and operand.
// Assumes: Both inputs are already gated by the caller.
// Notes:   Carry out is dropped, so sums wrap at sixteen bits.
`timescale 1ns/1ps
module adder16
(
	input  wire logic [15:0] a_i,
	input  wire logic [15:0] b_i,
	input  wire logic        cin_i,
	output logic      [15:0] sum_o
);

	logic [16:0] full;

	assign full  = {1'b0, a_i} + {1'b0, b_i} + {16'h0000, cin_i};
	assign sum_o = full[15:0];

endmodule // adder16

/* File: testbench/f2_exec_props.sv */
// Purpose: Port-level timing checks for the format 2 execution block.
// Assumes: Ten phases per cycle, one phase every four clocks.
// Notes:   Attached to every instance of the block by bind.
`timescale 1ns/1ps
`include "f2_exec_defs.svh"
module f2_exec_props
	import f2_exec_pkg::*;
(
	input wire logic        clk_i,
	input wire logic        rst_n_i,
	input wire logic [15:0] mem_data_i,
	input wire logic [15:0] pointer_i,
	input wire logic        jump_i,
	input wire logic        jump_cond_i,
	input wire logic [15:0] addr_o,
	input wire logic        mem_read_o,
	input wire cycle_t      cycle_o,
	input wire logic [3:0]  phase_o,
	input wire arch_regs_t  regs_o,
	input wire logic        condition_flag_o,
	input wire logic        indirect_cycle_two_o,
	input wire logic        next_fetch_status_o,
	input wire byte_ctl_t   byte_ctl_o
);
	logic [7:0] acc_hi;

	assign acc_hi = regs_o.acc[15:8];
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	read_pulse_a: assert property (mem_read_o |-> phase_o == `F2_T01 ##1 !mem_read_o)
		else $error("memory read pulse misplaced");
	phase_step_a: assert property ($changed(phase_o) |=> $stable(phase_o) [*3])
		else $error("phase stepped too early");
	cycle_edge_a: assert property ($changed(cycle_o) |-> phase_o == `F2_T00)
		else $error("cycle changed away from T00");
	ind_addr_a: assert property ($changed(cycle_o) && cycle_o == CYC_INDIRECT
		|-> addr_o[15:8] == 8'h00) else $error("indirect pointer address not plain");
	fetch_status_a: assert property (!next_fetch_status_o
		|-> cycle_o == CYC_FETCH && phase_o >= `F2_T06)
		else $error("fetch status low outside fetch");
	ind_two_a: assert property ($rose(indirect_cycle_two_o)
		|-> cycle_o == CYC_INDIRECT && phase_o == `F2_T01)
		else $error("cycle-two flag set at wrong time");
	cond_time_a: assert property ($changed(condition_flag_o)
		|-> phase_o == `F2_T00 && $past(cycle_o) == CYC_OPERAND)
		else $error("condition flag changed outside operand end");
	index_time_a: assert property ($changed(regs_o.idx1) || $changed(regs_o.idx2)
		|-> phase_o == `F2_T00) else $error("index written off T00");
	acc_time_a: assert property ($changed(regs_o.acc) |-> phase_o == `F2_T00
		|| (phase_o == `F2_T05 && byte_ctl_o.byte_load_clock_enable))
		else $error("accumulator written at wrong phase");
	byte_rise_a: assert property ($rose(byte_ctl_o.right_shift_eight)
		|-> phase_o == `F2_T01 && cycle_o == CYC_FETCH)
		else $error("byte controls rose off T01");
	byte_fall_a: assert property ($fell(byte_ctl_o.right_shift_eight)
		|-> phase_o == `F2_T00) else $error("byte controls fell early");
	byte_same_a: assert property (byte_ctl_o != 3'h0 |-> byte_ctl_o == 3'h7)
		else $error("byte controls disagree");
	shift_load_a: assert property (byte_ctl_o.byte_load_clock_enable
		&& $changed(phase_o) && phase_o == `F2_T05
		|-> regs_o.acc == {8'h00, $past(acc_hi)})
		else $error("byte shift result wrong");
endmodule // f2_exec_props

bind format2_address_and_load_exec f2_exec_props f2_exec_props_i (
	.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_data_i(mem_data_i),
	.pointer_i(pointer_i), .jump_i(jump_i), .jump_cond_i(jump_cond_i),
	.addr_o(addr_o), .mem_read_o(mem_read_o), .cycle_o(cycle_o),
	.phase_o(phase_o), .regs_o(regs_o),
	.condition_flag_o(condition_flag_o),
	.indirect_cycle_two_o(indirect_cycle_two_o),
	.next_fetch_status_o(next_fetch_status_o), .byte_ctl_o(byte_ctl_o));

/* File: testbench/memory_model.sv */
// Purpose: Behavioural main memory seen through the address register.
// Assumes: A read is sampled by the block before phase T06 ends.
// Notes:   The bench preloads words by hierarchical write.
`timescale 1ns/1ps
module memory_model
(
	input  wire logic [15:0] addr_i,
	input  wire logic [3:0]  phase_i,
	output logic      [15:0] data_o
);
	logic [15:0] mem_words [0:65535];
	logic        read_window;

	// Outside the read window the bus shows the inverse, so a late
	// sample cannot pass by luck.
	assign read_window = (phase_i >= 4'h1) && (phase_i <= 4'h6);
	assign data_o = read_window ? mem_words[addr_i] : ~mem_words[addr_i];

	initial
	begin
		for (int i = 0; i < 65536; i++)
			mem_words[i] = 16'h0000;
	end
endmodule // memory_model

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench for the format 2 execution block.
// Assumes: The next-instruction pointer stays at one fixed address.
// Notes:   Each instruction is placed at the fetch address, then cleared.
`timescale 1ns/1ps
`define CHECK_EQ(got, exp) \
	begin \
		total_checks++; \
		if ((got) !== (exp)) \
		begin \
			bad_count++; \
			$display("[FAIL] %0t got %h exp %h", $time, (got), (exp)); \
		end \
	end
module tb_top;
	import f2_exec_pkg::*;
	localparam logic [15:0] PTR = 16'h0200;
	logic        clk_i = 1'b0;
	logic        rst_n_i;
	logic        jump_i;
	logic        jump_cond_i;
	logic        mem_read_o;
	logic        condition_flag_o;
	logic        indirect_cycle_two_o;
	logic        next_fetch_status_o;
	logic        saw_ind;
	logic        saw_nfs;
	logic [15:0] mem_data_i;
	logic [15:0] addr_o;
	logic [15:0] fa;
	logic [3:0]  phase_o;
	cycle_t      cycle_o;
	arch_regs_t  regs_o;
	byte_ctl_t   byte_ctl_o;
	int          bad_count;
	int          total_checks;

	always #12.5 clk_i = ~clk_i;

	format2_address_and_load_exec format2_address_and_load_exec_i (
		.clk_i(clk_i), .rst_n_i(rst_n_i), .mem_data_i(mem_data_i),
		.pointer_i(PTR), .jump_i(jump_i), .jump_cond_i(jump_cond_i),
		.addr_o(addr_o), .mem_read_o(mem_read_o), .cycle_o(cycle_o),
		.phase_o(phase_o), .regs_o(regs_o),
		.condition_flag_o(condition_flag_o),
		.indirect_cycle_two_o(indirect_cycle_two_o),
		.next_fetch_status_o(next_fetch_status_o), .byte_ctl_o(byte_ctl_o));
	memory_model memory_model_i (.addr_i(addr_o), .phase_i(phase_o),
		.data_o(mem_data_i));

	task automatic test_done();
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic wait_phase(input logic [3:0] p);
		for (int n = 0; n < 100; n++)
		begin
			@(negedge clk_i);
			if (phase_o === p)
				return;
		end
		bad_count++;
		$display("[FAIL] %0t phase wait ran out", $time);
		test_done();
	endtask

	// Returns at phase T00 of the next fetch, noting indirect cycles seen.
	task automatic next_fetch();
		logic seen9;
		seen9 = 1'b0;
		saw_ind = 1'b0;
		saw_nfs = 1'b0;
		for (int n = 0; n < 500; n++)
		begin
			@(negedge clk_i);
			if (cycle_o === CYC_INDIRECT)
				saw_ind = 1'b1;
			if (next_fetch_status_o === 1'b0)
				saw_nfs = 1'b1;
			if (phase_o === 4'h9)
				seen9 = 1'b1;
			if (seen9 && phase_o === 4'h0 && cycle_o === CYC_FETCH)
				return;
		end
		bad_count++;
		$display("[FAIL] %0t fetch wait ran out", $time);
		test_done();
	endtask

	task automatic exec(input logic [15:0] ins);
		next_fetch();
		fa = addr_o;
		memory_model_i.mem_words[fa] = ins;
		next_fetch();
		memory_model_i.mem_words[fa] = 16'h0000;
	endtask

	task automatic t_enter_modes();
		logic [15:0] ins [8];
		logic [15:0] res [8];
		logic [15:0] exp;
		ins = '{16'h1805, 16'h1905, 16'h1A07, 16'h1B05,
			16'h1C10, 16'h1D10, 16'h1E10, 16'h1F03};
		res = '{16'h0005, 16'h0003, 16'h0027, 16'h0005,
			16'hFFFE, 16'hFFFC, 16'h001E, 16'h0003};
		memory_model_i.mem_words[16'h0010] = 16'hFFFE;
		exec(16'h2410);
		`CHECK_EQ(regs_o.idx1, 16'hFFFE)
		exec(16'h2820);
		`CHECK_EQ(regs_o.idx2, 16'h0020)
		for (int k = 0; k < 8; k++)
		begin
			exec(ins[k]);
			exp = (k == 3) ? fa + res[k] : (k == 7) ? fa - res[k] : res[k];
			`CHECK_EQ(regs_o.acc, exp)
			`CHECK_EQ(saw_ind, (k >= 4 && k <= 6))
			`CHECK_EQ(saw_nfs, (k >= 4 && k <= 6))
		end
		$display("test enter_modes done");
	endtask

	task automatic t_test_index();
		memory_model_i.mem_words[16'h0030] = 16'hFFFE;
		exec(16'h3030);
		`CHECK_EQ(condition_flag_o, 1'b1)
		`CHECK_EQ(regs_o.idx1, 16'hFFFE)
		memory_model_i.mem_words[16'h0030] = 16'h1234;
		exec(16'h3030);
		`CHECK_EQ(condition_flag_o, 1'b0)
		`CHECK_EQ(regs_o.idx1, 16'hFFFF)
		memory_model_i.mem_words[16'h0030] = 16'h0020;
		exec(16'h3830);
		`CHECK_EQ(condition_flag_o, 1'b1)
		`CHECK_EQ(regs_o.idx2, 16'h0020)
		memory_model_i.mem_words[16'h0030] = 16'h0000;
		exec(16'h3830);
		`CHECK_EQ(condition_flag_o, 1'b0)
		`CHECK_EQ(regs_o.idx2, 16'h0021)
		$display("test test_index done");
	endtask

	task automatic t_load();
		memory_model_i.mem_words[16'h0040] = 16'h8001;
		exec(16'h4040);
		`CHECK_EQ(regs_o.acc, 16'h8001)
		exec(16'h4840);
		`CHECK_EQ(regs_o.acc, 16'h7FFF)
		memory_model_i.mem_words[16'h0040] = 16'h0001;
		exec(16'h4840);
		`CHECK_EQ(regs_o.acc, 16'hFFFF)
		$display("test load done");
	endtask

	task automatic t_load_left();
		memory_model_i.mem_words[16'h0040] = 16'hABCD;
		exec(16'h5040);
		`CHECK_EQ(regs_o.acc, 16'hAB00)
		`CHECK_EQ(byte_ctl_o, 3'h0)
		wait_phase(4'h1);
		`CHECK_EQ(byte_ctl_o, 3'h7)
		wait_phase(4'h6);
		`CHECK_EQ(regs_o.acc, 16'h00AB)
		wait_phase(4'h9);
		`CHECK_EQ(byte_ctl_o, 3'h7)
		$display("test load_left done");
	endtask

	task automatic t_jump_skip();
		jump_i = 1'b1;
		jump_cond_i = 1'b0;
		exec(16'h1C10);
		`CHECK_EQ(saw_ind, 1'b0)
		`CHECK_EQ(saw_nfs, 1'b0)
		`CHECK_EQ(addr_o, PTR)
		`CHECK_EQ(regs_o.acc, 16'h00AB)
		jump_cond_i = 1'b1;
		exec(16'h1C10);
		`CHECK_EQ(saw_ind, 1'b1)
		`CHECK_EQ(regs_o.acc, 16'hFFFE)
		jump_i = 1'b0;
		$display("test jump_skip done");
	endtask

	initial
	begin
		rst_n_i = 1'b0;
		jump_i = 1'b0;
		jump_cond_i = 1'b0;
		bad_count = 0;
		total_checks = 0;
		repeat (16) @(negedge clk_i);
		rst_n_i = 1'b1;
		t_enter_modes();
		t_test_index();
		t_load();
		t_load_left();
		t_jump_skip();
		test_done();
	end
endmodule // tb_top
